/* rtl/ext_ctrl_pkg.sv */
// Package: offsets, field positions, thresholds and timing for the extended control bank
package ext_ctrl_pkg;
   localparam logic [2:0] OFF_DIV_LO   = 3'h0;
   localparam logic [2:0] OFF_DIV_HI   = 3'h1;
   localparam logic [2:0] OFF_EXT_ONE  = 3'h2;
   localparam logic [2:0] OFF_LINK_CTL = 3'h3;
   localparam logic [2:0] OFF_EXT_TWO  = 3'h4;
   localparam logic [2:0] OFF_RSVD5    = 3'h5;
   localparam logic [2:0] OFF_TX_LVL   = 3'h6;
   localparam logic [2:0] OFF_RX_LVL   = 3'h7;
   localparam logic [2:0] BANK_LEGACY  = 3'h1;
   localparam logic [2:0] BANK_EXT     = 3'h2;
   localparam int BIT_EXT_SEL   = 0;
   localparam int BIT_FAIRNESS  = 1;
   localparam int BIT_DMA_TH    = 2;
   localparam int BIT_SWAP      = 3;
   localparam int BIT_LOOP      = 4;
   localparam int BIT_TX_LOOP   = 5;
   localparam int BIT_BAUD_TEST = 7;
   localparam int BIT_LOCK      = 7;
   localparam int BIT_BANK_EN   = 7;
   localparam logic [7:0] EXT_ONE_RESET  = 8'h00;
   localparam logic [7:0] EXT_TWO_RESET  = 8'h00;
   localparam logic [7:0] EXT_TWO_MASK   = 8'hB0;
   localparam logic [7:0] FALLBACK_ONE_U = 8'hA0;
   localparam logic [7:0] FALLBACK_ONE_X = 8'hA1;
   localparam logic [7:0] FALLBACK_TWO   = 8'h3F;
   localparam logic [1:0] PRE_13    = 2'b00;
   localparam logic [1:0] PRE_1P625 = 2'b01;
   localparam logic [1:0] PRE_1     = 2'b11;
   localparam logic [4:0] TX_TH_LO = 5'h0D;
   localparam logic [4:0] TX_TH_HI = 5'h07;
   localparam logic [4:0] RX_TH_LO = 5'h04;
   localparam logic [4:0] RX_TH_HI = 5'h0A;
   localparam int FIFO_DEPTH = 16;
   localparam int CLK_MHZ = 24;
   localparam int FAIR_NS = 10500;
   localparam int FAIR_CYCLES = (FAIR_NS * CLK_MHZ) / 1000;
   localparam logic [3:0] BAUD_OVERSAMPLE = 4'hF;
   typedef struct packed {
      logic tx_req;
      logic rx_req;
   } dma_req_t;
   typedef struct packed {
      logic tx_ack;
      logic rx_ack;
   } dma_ack_t;
   typedef struct packed {
      logic dtr;
      logic rts;
      logic out1;
      logic out2;
   } modem_out_t;
   typedef struct packed {
      logic dsr;
      logic cts;
      logic ri;
      logic dcd;
   } modem_in_t;
endpackage : ext_ctrl_pkg

/* rtl/uart_extended_control_bank.sv */
// Extended control and status bank with baud generator, DMA gating and loopback routing
//
// Overview of operation
// - Bank two decodes offsets 00h to 07h.
// - Alternate divisor ports never cause fallback.
// - Either divisor write reloads the baud counter next cycle.
// - Control one resets zero, bit0 extended.
// - Fairness clear: drop DMA after 10.5us.
// - Fairness set: drop on FIFO full/empty.
// - Transmit request below 13 or 7.
// - Receive request at 4/10 or timeout.
// - Swap bit exchanges DMA request/acknowledge routing.
// - Loopback bit is control one bit4.
// - Extended loopback: DTR->DSR,RI; RTS->CTS,DCD.
// - Loopback modem status from modem control bits.
// - Loopback disconnects inputs, receiver fed internally.
// - Loopback holds serial high, infrared low, unless bit5 set.
// - Baud test drives generator onto DTR.
// - Prescaler divides by 13, 1.625, 1.
// - Lock redirects legacy divisor to scratchpads in non-extended mode.
// - Offset 05h resets and reads zero.
// - Transmit level register is read-only count.
// - Levels in bits 4-0, upper zero.
// - Unlocked legacy divisor access forces fallback.
// - Divisor makes 16x clock, then divide 16.
module uart_extended_control_bank
   import ext_ctrl_pkg::*;
#(
   parameter int LVL_W = 5
) (
   input  wire logic       MCLK,
   input  wire logic       RSTN,
   input  wire logic [2:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic [LVL_W-1:0] TX_LEVEL,
   input  wire logic [LVL_W-1:0] RX_LEVEL,
   input  wire logic       RX_DMA_TIMEOUT,
   input  wire dma_ack_t   DMA_ACK_IN,
   output dma_ack_t        DMA_ACK_OUT,
   output dma_req_t        DMA_REQ,
   input  wire logic       TX_SER_INT,
   input  wire logic       TX_IR_INT,
   input  wire logic       SIN,
   input  wire logic       IRRX,
   input  wire modem_in_t  MODEM_PINS,
   input  wire modem_out_t MODEM_CTL,
   output logic            RX_SER_INT,
   output logic            RX_IR_INT,
   output logic            SOUT,
   output logic            IRTX,
   output modem_out_t      MODEM_OUT,
   output modem_in_t       MODEM_STATUS,
   input  wire logic       IR_MODE,
   input  wire logic       IR_MS_SELECT,
   output logic            MS_INT_ENABLE,
   output logic            BAUD_16X_EN,
   output logic            BAUD_EN,
   output logic            EXTENDED_MODE,
   output logic            LOOPBACK
);
   // Read mux and thresholds assume five-bit levels
   if (LVL_W != 5) begin : g_lvl_check
      $error("level width must be 5");
   end

   ////////////////////////////////////////////////////////////////////////////////
   logic rst_s1_q, rst_s2_q;
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire rst_n = rst_s2_q;

   // Pin inputs pass two flops before use
   logic [1:0] sin_s_q, irrx_s_q;
   modem_in_t  mp_s1_q, mp_s2_q;
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         sin_s_q  <= 2'b11;
         irrx_s_q <= 2'b00;
         mp_s1_q  <= '0;
         mp_s2_q  <= '0;
      end else begin
         sin_s_q  <= {sin_s_q[0], SIN};
         irrx_s_q <= {irrx_s_q[0], IRRX};
         mp_s1_q  <= MODEM_PINS;
         mp_s2_q  <= mp_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] div_lo_q, div_hi_q, ext_one_q, ext_two_q, link_q, scr_lo_q, scr_hi_q;
   logic       reload_q;

   wire       sel_bank2 = link_q[BIT_BANK_EN] && (link_q[2:0] == BANK_EXT);
   wire       sel_bank1 = link_q[BIT_BANK_EN] && (link_q[2:0] == BANK_LEGACY);
   wire       ext_mode  = ext_one_q[BIT_EXT_SEL];
   wire       locked    = ext_two_q[BIT_LOCK] && !ext_mode;
   wire       acc       = WR || RD;
   wire       div_acc   = (ADDR == OFF_DIV_LO) || (ADDR == OFF_DIV_HI);
   wire       legacy_div = sel_bank1 && acc && div_acc;
   wire       fallback  = legacy_div && !locked;
   wire       wr_div_lo = WR && ((sel_bank2 && ADDR == OFF_DIV_LO) || (fallback && ADDR == OFF_DIV_LO));
   wire       wr_div_hi = WR && ((sel_bank2 && ADDR == OFF_DIV_HI) || (fallback && ADDR == OFF_DIV_HI));
   wire       wr_scr_lo = WR && legacy_div && locked && ADDR == OFF_DIV_LO;
   wire       wr_scr_hi = WR && legacy_div && locked && ADDR == OFF_DIV_HI;
   wire       wr_e1     = WR && sel_bank2 && ADDR == OFF_EXT_ONE;
   wire       wr_e2     = WR && sel_bank2 && ADDR == OFF_EXT_TWO;
   wire       wr_link   = WR && ADDR == OFF_LINK_CTL;
   wire [7:0] fb_one    = ext_mode ? FALLBACK_ONE_X : FALLBACK_ONE_U;

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         div_lo_q  <= 8'h00;
         div_hi_q  <= 8'h00;
         ext_one_q <= EXT_ONE_RESET;
         ext_two_q <= EXT_TWO_RESET;
         link_q    <= 8'h00;
         scr_lo_q  <= 8'h00;
         scr_hi_q  <= 8'h00;
         reload_q  <= 1'b0;
      end else begin
         reload_q <= wr_div_hi || wr_div_lo;
         if (wr_div_lo) div_lo_q <= WDATA;
         if (wr_div_hi) div_hi_q <= WDATA;
         if (wr_scr_lo) scr_lo_q <= WDATA;
         if (wr_scr_hi) scr_hi_q <= WDATA;
         if (wr_link) link_q <= WDATA;
         if (fallback) begin
            ext_one_q <= ext_one_q & ~fb_one;
            ext_two_q <= ext_two_q & ~FALLBACK_TWO;
         end else begin
            if (wr_e1) ext_one_q <= WDATA;
            if (wr_e2) ext_two_q <= WDATA & EXT_TWO_MASK;
         end
      end
   end

   // Loopback storage held in control one bit 4
   wire loop_on = ext_one_q[BIT_LOOP];

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux; data stands one cycle after the strobe
   wire [7:0] rd_lvl_tx = {3'b000, TX_LEVEL};
   wire [7:0] rd_lvl_rx = {3'b000, RX_LEVEL};
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (ADDR == OFF_LINK_CTL) rd_mux = link_q;
      else if (sel_bank1 && locked && ADDR == OFF_DIV_LO) rd_mux = scr_lo_q;
      else if (sel_bank1 && locked && ADDR == OFF_DIV_HI) rd_mux = scr_hi_q;
      else if (sel_bank1 && ADDR == OFF_DIV_LO) rd_mux = div_lo_q;
      else if (sel_bank1 && ADDR == OFF_DIV_HI) rd_mux = div_hi_q;
      else if (sel_bank2 && ADDR == OFF_DIV_LO) rd_mux = div_lo_q;
      else if (sel_bank2 && ADDR == OFF_DIV_HI) rd_mux = div_hi_q;
      else if (sel_bank2 && ADDR == OFF_EXT_ONE) rd_mux = ext_one_q;
      else if (sel_bank2 && ADDR == OFF_EXT_TWO) rd_mux = ext_two_q;
      else if (sel_bank2 && ADDR == OFF_RSVD5) rd_mux = 8'h00;
      else if (sel_bank2 && ADDR == OFF_TX_LVL) rd_mux = rd_lvl_tx;
      else if (sel_bank2 && ADDR == OFF_RX_LVL) rd_mux = rd_lvl_rx;
   end
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) RDATA <= 8'h00;
      else if (RD) RDATA <= rd_mux;
      else RDATA <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler: 1.625 done as 8 enables per 13 input clocks
   logic [3:0] pre_cnt_q;
   logic [3:0] frac_q;
   logic       pre_en_q;
   wire [1:0]  presel = ext_two_q[5:4];
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_q <= 4'h0;
         frac_q    <= 4'h0;
         pre_en_q  <= 1'b0;
      end else begin
         pre_en_q <= 1'b0;
         case (presel)
            PRE_13: begin
               pre_en_q  <= (pre_cnt_q == 4'hC);
               pre_cnt_q <= (pre_cnt_q == 4'hC) ? 4'h0 : pre_cnt_q + 4'h1;
            end
            PRE_1P625: begin
               pre_en_q <= (frac_q >= 4'h5);
               frac_q   <= (frac_q >= 4'h5) ? frac_q - 4'h5 : frac_q + 4'h8;
            end
            PRE_1: pre_en_q <= 1'b1;
            default: pre_en_q <= 1'b0;
         endcase
      end
   end

   // Divisor counter feeds 16x enable, then divide by 16
   logic [15:0] bcnt_q;
   logic [3:0]  os_q;
   logic        b16_q, b1_q, bclk_q;
   wire  [15:0] divisor = {div_hi_q, div_lo_q};
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         bcnt_q <= 16'h0000;
         os_q   <= 4'h0;
         b16_q  <= 1'b0;
         b1_q   <= 1'b0;
         bclk_q <= 1'b0;
      end else begin
         b16_q <= 1'b0;
         b1_q  <= 1'b0;
         if (reload_q) begin
            bcnt_q <= divisor;
         end else if (pre_en_q && divisor != 16'h0000) begin
            if (bcnt_q <= 16'h0001) begin
               bcnt_q <= divisor;
               b16_q  <= 1'b1;
               bclk_q <= ~bclk_q;
               os_q   <= os_q + 4'h1;
               b1_q   <= (os_q == BAUD_OVERSAMPLE);
            end else begin
               bcnt_q <= bcnt_q - 16'h0001;
            end
         end
      end
   end
   assign BAUD_16X_EN = b16_q;
   assign BAUD_EN     = b1_q;

   ////////////////////////////////////////////////////////////////////////////////
   // DMA requests and fairness timer
   wire       th_sel = ext_one_q[BIT_DMA_TH];
   wire       fair   = ext_one_q[BIT_FAIRNESS];
   wire [4:0] tx_th  = th_sel ? TX_TH_HI : TX_TH_LO;
   wire [4:0] rx_th  = th_sel ? RX_TH_HI : RX_TH_LO;
   wire       tx_raw = TX_LEVEL < tx_th;
   wire       rx_raw = (RX_LEVEL >= rx_th) || RX_DMA_TIMEOUT;
   wire       tx_full  = TX_LEVEL == 5'(FIFO_DEPTH);
   wire       rx_empty = RX_LEVEL == 5'h00;
   logic [15:0] fair_q;
   logic        cut_q;
   wire         busy = tx_raw || rx_raw;
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         fair_q <= 16'h0000;
         cut_q  <= 1'b0;
      end else if (!busy || fair) begin
         fair_q <= 16'h0000;
         cut_q  <= 1'b0;
      end else if (fair_q >= 16'(FAIR_CYCLES - 1)) begin
         cut_q <= 1'b1;
      end else begin
         fair_q <= fair_q + 16'h0001;
      end
   end
   wire tx_req = tx_raw && (fair ? !tx_full : !cut_q);
   wire rx_req = rx_raw && (fair ? !rx_empty : !cut_q);
   wire swap   = ext_one_q[BIT_SWAP];
   assign DMA_REQ.tx_req     = swap ? rx_req : tx_req;
   assign DMA_REQ.rx_req     = swap ? tx_req : rx_req;
   assign DMA_ACK_OUT.tx_ack = swap ? DMA_ACK_IN.rx_ack : DMA_ACK_IN.tx_ack;
   assign DMA_ACK_OUT.rx_ack = swap ? DMA_ACK_IN.tx_ack : DMA_ACK_IN.rx_ack;

   ////////////////////////////////////////////////////////////////////////////////
   // Loopback routing; modem control bits come from an outside register image
   modem_out_t mc;
   assign mc = MODEM_CTL;
   wire tx_loop = ext_one_q[BIT_TX_LOOP];
   assign RX_SER_INT = loop_on ? TX_SER_INT : sin_s_q[1];
   assign RX_IR_INT  = loop_on ? TX_IR_INT : irrx_s_q[1];
   assign SOUT = (loop_on && !tx_loop) ? 1'b1 : TX_SER_INT;
   assign IRTX = (loop_on && !tx_loop) ? 1'b0 : TX_IR_INT;
   always_comb begin
      MODEM_STATUS = mp_s2_q;
      if (loop_on && ext_mode) begin
         MODEM_STATUS = '{dsr: mc.dtr, cts: mc.rts, ri: mc.dtr, dcd: mc.rts};
      end else if (loop_on) begin
         MODEM_STATUS = '{dsr: mc.dtr, cts: mc.rts, ri: mc.out1, dcd: mc.out2};
      end
   end
   assign MS_INT_ENABLE = !IR_MODE || !IR_MS_SELECT;
   assign MODEM_OUT.dtr  = ext_one_q[BIT_BAUD_TEST] ? bclk_q : (loop_on ? 1'b0 : mc.dtr);
   assign MODEM_OUT.rts  = loop_on ? 1'b0 : mc.rts;
   assign MODEM_OUT.out1 = loop_on ? 1'b0 : mc.out1;
   assign MODEM_OUT.out2 = loop_on ? 1'b0 : mc.out2;
   assign EXTENDED_MODE  = ext_mode;
   assign LOOPBACK       = loop_on;
endmodule : uart_extended_control_bank

/* bench/uart_ecb_asserts.sv */
// Port relation checker for the extended control bank
module uart_ecb_asserts
   import ext_ctrl_pkg::*;
#(
   parameter int LVL_W = 5
) (
   input wire logic             MCLK,
   input wire logic             RSTN,
   input wire logic [2:0]       ADDR,
   input wire logic [7:0]       WDATA,
   input wire logic             WR,
   input wire logic             RD,
   input wire logic [7:0]       RDATA,
   input wire logic [LVL_W-1:0] TX_LEVEL,
   input wire dma_ack_t         DMA_ACK_IN,
   input wire dma_ack_t         DMA_ACK_OUT,
   input wire logic             TX_SER_INT,
   input wire logic             TX_IR_INT,
   input wire logic             RX_SER_INT,
   input wire logic             RX_IR_INT,
   input wire logic             SOUT,
   input wire logic             IRTX,
   input wire modem_in_t        MODEM_STATUS,
   input wire logic             EXTENDED_MODE,
   input wire logic             LOOPBACK
);
   logic bank2_q;
   // Bank followed from link byte writes; fallback leaves it alone
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) bank2_q <= 1'b0;
      else if (WR && ADDR == OFF_LINK_CTL) bank2_q <= WDATA[BIT_BANK_EN] && WDATA[2:0] == BANK_EXT;
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   rdata_idle_a: assert property (!RD |=> RDATA == 8'h00) else $error("read data not idle");
   level_read_a: assert property (RD && bank2_q && ADDR == OFF_TX_LVL |=> RDATA == 8'($past(TX_LEVEL)))
      else $error("tx level read wrong");
   rsvd_read_a: assert property (RD && bank2_q && ADDR == OFF_RSVD5 |=> RDATA == 8'h00)
      else $error("reserved read not zero");
   loop_out_a: assert property (LOOPBACK |-> (SOUT && !IRTX) || (SOUT == TX_SER_INT && IRTX == TX_IR_INT))
      else $error("loopback line outputs wrong");
   loop_rx_a: assert property (LOOPBACK |-> RX_SER_INT == TX_SER_INT && RX_IR_INT == TX_IR_INT)
      else $error("loopback receiver feed wrong");
   loop_status_a: assert property (LOOPBACK && EXTENDED_MODE |-> MODEM_STATUS.dsr == MODEM_STATUS.ri
      && MODEM_STATUS.cts == MODEM_STATUS.dcd) else $error("loopback status pairing wrong");
   ack_route_a: assert property ({DMA_ACK_OUT} == {DMA_ACK_IN}
      || {DMA_ACK_OUT} == {DMA_ACK_IN.rx_ack, DMA_ACK_IN.tx_ack}) else $error("ack routing wrong");
   mode_cause_a: assert property (!$stable(EXTENDED_MODE) |-> $past(WR) || $past(RD))
      else $error("mode changed without access");
endmodule : uart_ecb_asserts

bind uart_extended_control_bank uart_ecb_asserts #(.LVL_W(LVL_W)) u_chk (.MCLK(MCLK), .RSTN(RSTN),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TX_LEVEL(TX_LEVEL),
   .DMA_ACK_IN(DMA_ACK_IN), .DMA_ACK_OUT(DMA_ACK_OUT), .TX_SER_INT(TX_SER_INT), .TX_IR_INT(TX_IR_INT),
   .RX_SER_INT(RX_SER_INT), .RX_IR_INT(RX_IR_INT), .SOUT(SOUT), .IRTX(IRTX),
   .MODEM_STATUS(MODEM_STATUS), .EXTENDED_MODE(EXTENDED_MODE), .LOOPBACK(LOOPBACK));

/* bench/dma_host_model.sv */
// DMA controller model acknowledging each request channel
module dma_host_model
   import ext_ctrl_pkg::*;
(
   input  wire logic     MCLK,
   input  wire logic     RSTN,
   input  wire logic     slow,
   input  wire dma_req_t req,
   output dma_ack_t      ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] dly_q;
   // Slow mode answers three cycles after the request, to stretch bursts
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) dly_q <= 6'h00;
      else dly_q <= {dly_q[3:0], req};
   end
   assign ack = slow ? dma_ack_t'(dly_q[5:4]) : dma_ack_t'(dly_q[1:0]);
endmodule : dma_host_model

/* bench/tb_uart_extended_control_bank.sv */
// Self-checking bench for the extended control bank
module tb_uart_extended_control_bank
   import ext_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       MCLK = 1'b0;
   logic       RSTN = 1'b0;
   logic [2:0] ADDR = 3'h0;
   logic [7:0] WDATA = 8'h00;
   logic [4:0] TX_LEVEL = 5'h10;
   logic [4:0] RX_LEVEL = 5'h00;
   logic       WR = 1'b0, RD = 1'b0, RX_DMA_TIMEOUT = 1'b0, TX_SER_INT = 1'b0, TX_IR_INT = 1'b1;
   logic       SIN = 1'b1, IRRX = 1'b0, IR_MODE = 1'b1, IR_MS_SELECT = 1'b0, slow = 1'b0;
   modem_in_t  MODEM_PINS = 4'hF;
   modem_out_t MODEM_CTL = 4'h0;
   logic [7:0] RDATA;
   logic       RX_SER_INT, RX_IR_INT, SOUT, IRTX, MS_INT_ENABLE, BAUD_16X_EN, BAUD_EN, EXTENDED_MODE, LOOPBACK;
   dma_ack_t   ack_in, ack_out;
   dma_req_t   DMA_REQ;
   modem_out_t MODEM_OUT;
   modem_in_t  MODEM_STATUS;
   int         n_mismatch = 0;
   int         check_count = 0;
   int         per;
   always #5 MCLK = ~MCLK;
   uart_extended_control_bank u_dut (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .TX_LEVEL(TX_LEVEL), .RX_LEVEL(RX_LEVEL), .RX_DMA_TIMEOUT(RX_DMA_TIMEOUT),
      .DMA_ACK_IN(ack_in), .DMA_ACK_OUT(ack_out), .DMA_REQ(DMA_REQ), .TX_SER_INT(TX_SER_INT),
      .TX_IR_INT(TX_IR_INT), .SIN(SIN), .IRRX(IRRX), .MODEM_PINS(MODEM_PINS), .RX_SER_INT(RX_SER_INT),
      .RX_IR_INT(RX_IR_INT), .SOUT(SOUT), .IRTX(IRTX), .MODEM_OUT(MODEM_OUT), .MODEM_STATUS(MODEM_STATUS),
      .IR_MODE(IR_MODE), .IR_MS_SELECT(IR_MS_SELECT), .MS_INT_ENABLE(MS_INT_ENABLE), .MODEM_CTL(MODEM_CTL),
      .BAUD_16X_EN(BAUD_16X_EN), .BAUD_EN(BAUD_EN), .EXTENDED_MODE(EXTENDED_MODE), .LOOPBACK(LOOPBACK));
   dma_host_model u_host (.MCLK(MCLK), .RSTN(RSTN), .slow(slow), .req(DMA_REQ), .ack(ack_in));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t value %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_n(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("[FAIL] %0t count %0d exp %0d to %0d", $time, got, lo, hi);
      end
   endtask : chk_n
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 chk(RDATA, exp);
   endtask : rd_chk
   // Bounded wait for the next baud pulse; n is the spacing in cycles
   task automatic gap(input logic sel, output int n);
      n = 0;
      do begin
         @(posedge MCLK);
         #1 n++;
      end while ((sel ? BAUD_EN : BAUD_16X_EN) !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         n_mismatch++;
         end_of_test();
      end
   endtask : gap
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd_chk(OFF_EXT_ONE, EXT_ONE_RESET);
      rd_chk(OFF_EXT_TWO, EXT_TWO_RESET);
      wr(OFF_RSVD5, 8'hFF);
      rd_chk(OFF_RSVD5, 8'h00);
      wr(OFF_TX_LVL, 8'hFF);
      wr(OFF_RX_LVL, 8'hFF);
      RX_LEVEL <= 5'h0B;
      rd_chk(OFF_TX_LVL, 8'h10);
      rd_chk(OFF_RX_LVL, 8'h0B);
      wr(OFF_EXT_ONE, 8'h01);
      wr(OFF_DIV_LO, 8'h0C);
      wr(OFF_DIV_HI, 8'h00);
      rd_chk(OFF_DIV_LO, 8'h0C);
      chk(8'(EXTENDED_MODE), 8'h01);
   endtask : t_regs
   task automatic t_fallback;
      wr(OFF_EXT_ONE, 8'hB1);
      wr(OFF_EXT_TWO, 8'h30);
      wr(OFF_LINK_CTL, 8'h81);
      wr(OFF_DIV_LO, 8'h04);
      wr(OFF_LINK_CTL, 8'h82);
      rd_chk(OFF_EXT_ONE, 8'h10);
      rd_chk(OFF_EXT_TWO, 8'h00);
      wr(OFF_EXT_ONE, 8'h00);
      wr(OFF_EXT_TWO, 8'hB0);
      wr(OFF_LINK_CTL, 8'h81);
      wr(OFF_DIV_LO, 8'h5A);
      rd_chk(OFF_DIV_LO, 8'h5A);
      wr(OFF_LINK_CTL, 8'h82);
      rd_chk(OFF_EXT_TWO, 8'hB0);
      rd_chk(OFF_DIV_LO, 8'h04);
   endtask : t_fallback
   task automatic t_dma;
      logic [7:0] ex [8] = '{8'h02, 8'h02, 8'h06, 8'h06, 8'h06, 8'h02, 8'h0A, 8'h0A};
      logic [4:0] tl [8] = '{5'h0C, 5'h0D, 5'h06, 5'h07, 5'h10, 5'h10, 5'h00, 5'h10};
      logic [4:0] rl [8] = '{5'h03, 5'h04, 5'h09, 5'h0A, 5'h05, 5'h00, 5'h01, 5'h05};
      logic [1:0] er [8] = '{2'b10, 2'b01, 2'b10, 2'b01, 2'b01, 2'b00, 2'b01, 2'b10};
      logic [7:0] tm = 8'h30;
      for (int i = 0; i < 8; i++) begin
         wr(OFF_EXT_ONE, ex[i]);
         TX_LEVEL <= tl[i];
         RX_LEVEL <= rl[i];
         RX_DMA_TIMEOUT <= tm[i];
         repeat (3) @(posedge MCLK);
         #1 chk(8'(DMA_REQ), {6'h00, er[i]});
         if (ex[i][BIT_SWAP]) chk(8'(ack_out), {6'h00, er[i][0], er[i][1]});
      end
   endtask : t_dma
   // Burst limit only counts once the request starts with fairness off
   task automatic t_fair;
      int n;
      wr(OFF_EXT_ONE, 8'h02);
      slow <= 1'b1;
      TX_LEVEL <= 5'h00;
      RX_LEVEL <= 5'h00;
      RX_DMA_TIMEOUT <= 1'b0;
      repeat (300) @(posedge MCLK);
      #1 chk(8'(DMA_REQ), 8'h02);
      @(posedge MCLK);
      TX_LEVEL <= 5'h10;
      wr(OFF_EXT_ONE, 8'h00);
      TX_LEVEL <= 5'h00;
      n = 0;
      do begin
         @(posedge MCLK);
         #1 n++;
      end while (DMA_REQ.tx_req === 1'b1 && n < 400);
      chk_n(n, 240, 264);
      if (n >= 400) end_of_test();
   endtask : t_fair
   task automatic t_loop;
      MODEM_CTL <= 4'h9;
      wr(OFF_EXT_ONE, 8'h11);
      repeat (4) @(posedge MCLK);
      #1 chk({2'b00, SOUT, IRTX, RX_SER_INT, RX_IR_INT, LOOPBACK, MS_INT_ENABLE}, 8'h27);
      chk(8'(MODEM_STATUS), 8'h0A);
      @(posedge MCLK);
      IR_MS_SELECT <= 1'b1;
      wr(OFF_EXT_ONE, 8'h31);
      #1 chk({2'b00, SOUT, IRTX, RX_SER_INT, RX_IR_INT, LOOPBACK, MS_INT_ENABLE}, 8'h16);
      wr(OFF_EXT_ONE, 8'h01);
      repeat (4) @(posedge MCLK);
      #1 chk({2'b00, SOUT, IRTX, RX_SER_INT, RX_IR_INT, LOOPBACK, MS_INT_ENABLE}, 8'h18);
      chk(8'(MODEM_STATUS), 8'h0F);
      chk(8'(MODEM_OUT), 8'h09);
      wr(OFF_EXT_ONE, 8'h10);
      #1 chk(8'(MODEM_STATUS), 8'h09);
   endtask : t_loop
   task automatic t_baud;
      logic [7:0] pre [3] = '{8'h30, 8'h00, 8'h10};
      logic [7:0] dl [3] = '{8'h04, 8'h04, 8'h08};
      int ep [3] = '{4, 52, 13};
      int t;
      logic p;
      for (int i = 0; i < 3; i++) begin
         wr(OFF_EXT_TWO, pre[i]);
         wr(OFF_DIV_LO, dl[i]);
         wr(OFF_DIV_HI, 8'h00);
         repeat (3) gap(1'b0, per);
         chk_n(per, ep[i], ep[i]);
      end
      repeat (3) gap(1'b1, per);
      chk_n(per, 208, 208);
      for (int b = 0; b < 2; b++) begin
         wr(OFF_EXT_ONE, b ? 8'h80 : 8'h00);
         t = 0;
         #1 p = MODEM_OUT.dtr;
         repeat (240) begin
            @(posedge MCLK);
            #1 t += (MODEM_OUT.dtr !== p);
            p = MODEM_OUT.dtr;
         end
         chk_n(t, b ? 18 : 0, b ? 19 : 0);
      end
   endtask : t_baud
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge MCLK);
      RSTN <= 1'b1;
      repeat (3) @(posedge MCLK);
      wr(OFF_LINK_CTL, 8'h82);
      t_regs();
      t_fallback();
      t_dma();
      t_fair();
      t_loop();
      t_baud();
      end_of_test();
   end
endmodule : tb_uart_extended_control_bank
